// File: hw/dspc_params.svh
/*
  Constants of the drive serial port control block: codes, defaults and timing.
  Assumes a single 100 MHz clock; the bit clock divisors are derived from it here.
*/
// How it works
// - Bit rate code 0..4, default 9600.
// - Parity code: none, even, odd; default none.
// - On comm fault pass stop-method code out.
// - Detection enable 0 never raises a fault.
// - Fault when silence exceeds loss-detection time.
// - Loss time 0.0 to 10.0 s, default 2.0.
// - Reply waits 5 to 65 ms after message.
// - Transmit request always on, or only sending.
// - Protocol code 0..2, default Modbus.
`ifndef DSPC_PARAMS_SVH
`define DSPC_PARAMS_SVH
// Clock period and the time units built on it.
`define DSPC_CLK_NS 10
`define DSPC_MS_NS 1000000
`define DSPC_DSEC_NS 100000000
`define DSPC_CLK_HZ 100000000
// Bit clock divisors, rounded down from the clock rate.
`define DSPC_DIV_1200 (`DSPC_CLK_HZ / 1200)
`define DSPC_DIV_2400 (`DSPC_CLK_HZ / 2400)
`define DSPC_DIV_4800 (`DSPC_CLK_HZ / 4800)
`define DSPC_DIV_9600 (`DSPC_CLK_HZ / 9600)
`define DSPC_DIV_19200 (`DSPC_CLK_HZ / 19200)
// Setting limits, in ms for the reply delay and tenths of a second for loss time.
`define DSPC_DLY_MIN 7'h05
`define DSPC_DLY_MAX 7'h41
`define DSPC_LOSS_MAX 7'h64
// Values the captured settings hold until the capture: 9600 baud and 2.0 s of loss time.
`define DSPC_BAUD_DEF 3'h3
`define DSPC_LOSS_DEF 7'h14
// Cycles the setting inputs settle through the synchroniser before capture.
`define DSPC_CAP_WAIT 2'h3
`endif

// File: hw/dspc_pkg.sv
/*
  Types of the drive serial port control block.
  Assumes dspc_params.svh holds the numeric constants.
*/
package dspc_pkg;
  // Stop method handed to motor control on a communication fault.
  typedef enum logic [1:0] {DSPC_RAMP = 2'h0, DSPC_COAST = 2'h1, DSPC_FAST = 2'h2, DSPC_ALARM = 2'h3} dspc_stop_t;
  // Message protocol.
  typedef enum logic [1:0] {DSPC_MODBUS = 2'h0, DSPC_BA1 = 2'h1, DSPC_BA2 = 2'h2} dspc_proto_t;
  // Reply sequencer states, one-hot.
  typedef enum logic [2:0] {ST_IDLE = 3'h1, ST_WAIT = 3'h2, ST_SEND = 3'h4} dspc_state_t;
endpackage : dspc_pkg

// File: hw/dspc_top.sv
/*
  Drive serial port control: setting capture, reply delay, transmit request,
  two-entry reply buffer and communication-loss supervision.
  Assumes the receiver and serialiser run on CLK; setting inputs are asynchronous straps.
*/
`timescale 1ns/1ps
`include "dspc_params.svh"
module dspc_top #(
  parameter int CYC_PER_MS = `DSPC_MS_NS / `DSPC_CLK_NS,
  parameter int CYC_PER_DSEC = `DSPC_DSEC_NS / `DSPC_CLK_NS,
  parameter int DW = 8
) (
  // Clock and reset.
  input wire logic CLK,
  input wire logic RSTN,
  // Setting inputs, read once after each reset.
  input wire logic [2:0] BAUD_SEL,
  input wire logic [1:0] PARITY_SEL,
  input wire dspc_pkg::dspc_stop_t STOP_SEL,
  input wire logic LOSS_DET_EN,
  input wire logic [6:0] COMM_LOSS_TIME,
  input wire logic [6:0] REPLY_DELAY_TIME,
  input wire logic TRANSMIT_REQUEST_CONTROL,
  input wire dspc_pkg::dspc_proto_t PROTOCOL_SEL,
  // Receiver event and serialiser status.
  input wire logic MSG_VALID,
  input wire logic TX_BUSY,
  // Reply words from the protocol engine.
  input wire logic [DW-1:0] IN_DATA,
  input wire logic IN_VALID,
  output logic IN_READY,
  // Reply words to the serialiser.
  output logic [DW-1:0] OUT_DATA,
  output logic OUT_VALID,
  input wire logic OUT_READY,
  // Applied configuration.
  output logic CFG_VALID,
  output logic [16:0] BAUD_DIV,
  output logic PARITY_EN,
  output logic PARITY_ODD,
  output dspc_pkg::dspc_proto_t PROTOCOL,
  // Supervision and line control.
  output logic COMM_FAULT,
  output dspc_pkg::dspc_stop_t STOP_METHOD,
  output logic XMIT_REQ
);
  import dspc_pkg::*;

  localparam int MSW = $clog2(CYC_PER_MS + 1);
  localparam int DSW = $clog2(CYC_PER_DSEC + 1);

  // Refuse prescalers the counters cannot serve.
  if (CYC_PER_MS < 1 || CYC_PER_DSEC < 1 || DW < 1) begin : g_chk
    $error("dspc_top: prescalers and width must be at least one");
  end

  // Bit-rate code to divisor; codes above 4 fall back to the default rate.
  function automatic logic [16:0] baud_div(input logic [2:0] code);
    case (code)
      3'h0: baud_div = 17'(`DSPC_DIV_1200);
      3'h1: baud_div = 17'(`DSPC_DIV_2400);
      3'h2: baud_div = 17'(`DSPC_DIV_4800);
      3'h4: baud_div = 17'(`DSPC_DIV_19200);
      default: baud_div = 17'(`DSPC_DIV_9600);
    endcase
  endfunction : baud_div

  logic [24:0] sync1_r, sync2_r; // Two-stage synchroniser for all 25 setting pin bits.
  logic [1:0] cap_cnt_r; // Settling count before capture.
  logic cfg_done_r; // Settings are captured and frozen.
  logic [2:0] baud_r; // Captured bit-rate code.
  logic [1:0] par_r; // Captured parity code.
  dspc_stop_t stop_r; // Captured stop method.
  logic det_en_r; // Captured detection enable.
  logic [6:0] loss_r; // Captured loss time, tenths of a second.
  logic [6:0] dly_r; // Captured reply delay, ms.
  logic xctl_r; // Captured transmit request control.
  dspc_state_t state_r, state_nxt; // Reply sequencer.
  logic [MSW-1:0] ms_pre_r; // Millisecond prescaler.
  logic [6:0] ms_cnt_r; // Milliseconds waited.
  logic [DSW-1:0] ds_pre_r; // Tenth-second prescaler.
  logic [6:0] loss_cnt_r; // Silent tenths of a second.
  logic [DW-1:0] tail_r; // Second buffer entry.
  logic [1:0] cnt_r, cnt_nxt; // Buffer fill.
  logic sent_r; // At least one reply word sent in this reply.
  logic ms_tick, ds_tick, push, pop;

  // Synchronise the straps; only the second stage is read.
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      sync1_r <= 25'h0;
      sync2_r <= 25'h0;
    end else begin
      sync1_r <= {BAUD_SEL, PARITY_SEL, STOP_SEL, LOSS_DET_EN, COMM_LOSS_TIME, REPLY_DELAY_TIME,
                  TRANSMIT_REQUEST_CONTROL, PROTOCOL_SEL};
      sync2_r <= sync1_r;
    end
  end

  // Capture once after release; later pin changes wait for the next reset.
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      cap_cnt_r <= 2'h0;
      cfg_done_r <= 1'b0;
      baud_r <= `DSPC_BAUD_DEF;
      par_r <= 2'h0;
      stop_r <= DSPC_ALARM;
      det_en_r <= 1'b1;
      loss_r <= `DSPC_LOSS_DEF;
      dly_r <= `DSPC_DLY_MIN;
      xctl_r <= 1'b1;
      PROTOCOL <= DSPC_MODBUS;
      BAUD_DIV <= 17'(`DSPC_DIV_9600);
      PARITY_EN <= 1'b0;
      PARITY_ODD <= 1'b0;
      STOP_METHOD <= DSPC_ALARM;
      CFG_VALID <= 1'b0;
    end else if (!cfg_done_r) begin
      if (cap_cnt_r != `DSPC_CAP_WAIT) begin
        cap_cnt_r <= cap_cnt_r + 2'h1;
      end else begin
        cfg_done_r <= 1'b1;
        CFG_VALID <= 1'b1;
        // Field positions follow the packing order of the synchroniser input above.
        baud_r <= sync2_r[24:22];
        BAUD_DIV <= baud_div(sync2_r[24:22]);
        par_r <= sync2_r[21:20];
        PARITY_EN <= sync2_r[21:20] == 2'h1 || sync2_r[21:20] == 2'h2;
        PARITY_ODD <= sync2_r[21:20] == 2'h2;
        stop_r <= dspc_stop_t'(sync2_r[19:18]);
        STOP_METHOD <= dspc_stop_t'(sync2_r[19:18]);
        det_en_r <= sync2_r[17];
        // Out-of-range loss and delay times are clamped to the nearest legal value.
        loss_r <= sync2_r[16:10] > `DSPC_LOSS_MAX ? `DSPC_LOSS_MAX : sync2_r[16:10];
        dly_r <= sync2_r[9:3] < `DSPC_DLY_MIN ? `DSPC_DLY_MIN :
                 sync2_r[9:3] > `DSPC_DLY_MAX ? `DSPC_DLY_MAX : sync2_r[9:3];
        xctl_r <= sync2_r[2];
        PROTOCOL <= sync2_r[1:0] > 2'h2 ? DSPC_MODBUS : dspc_proto_t'(sync2_r[1:0]);
      end
    end
  end

  // Prescalers; the ms one restarts with each message so the delay is exact.
  assign ms_tick = ms_pre_r == MSW'(CYC_PER_MS - 1);
  assign ds_tick = ds_pre_r == DSW'(CYC_PER_DSEC - 1);
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      ms_pre_r <= '0;
      ds_pre_r <= '0;
    end else begin
      ms_pre_r <= (MSG_VALID || ms_tick) ? '0 : ms_pre_r + MSW'(1);
      ds_pre_r <= (MSG_VALID || ds_tick) ? '0 : ds_pre_r + DSW'(1);
    end
  end

  // Loss supervision; a message clears the fault and the count, and wins over a tick.
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      loss_cnt_r <= 7'h0;
      COMM_FAULT <= 1'b0;
    end else if (!cfg_done_r || !det_en_r) begin
      loss_cnt_r <= 7'h0;
      COMM_FAULT <= 1'b0;
    end else if (MSG_VALID) begin
      loss_cnt_r <= 7'h0;
      COMM_FAULT <= 1'b0;
    end else if (ds_tick && !COMM_FAULT) begin
      loss_cnt_r <= loss_cnt_r + 7'h1;
      if (loss_cnt_r >= loss_r) begin
        COMM_FAULT <= 1'b1;
      end
    end
  end

  // Buffer handshakes; the serialiser only sees words while sending.
  assign push = IN_VALID && IN_READY;
  assign pop = OUT_VALID && OUT_READY;
  always_comb begin
    cnt_nxt = cnt_r + 2'(push) - 2'(pop);
  end

  // Reply sequencer: wait the delay after a message, then release the buffer.
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: if (MSG_VALID && cfg_done_r) begin
        state_nxt = ST_WAIT;
      end
      ST_WAIT: if (ms_tick && ms_cnt_r == dly_r - 7'h1) begin
        state_nxt = ST_SEND;
      end
      ST_SEND: if (sent_r && cnt_r == 2'h0 && !TX_BUSY) begin
        state_nxt = ST_IDLE;
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  // Sequencer state and delay count.
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      state_r <= ST_IDLE;
      ms_cnt_r <= 7'h0;
      sent_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      ms_cnt_r <= state_r != ST_WAIT ? 7'h0 : ms_cnt_r + 7'(ms_tick);
      sent_r <= state_r == ST_SEND && (sent_r || pop);
    end
  end

  // Transmit request; with control 0 it stays on after capture.
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      XMIT_REQ <= 1'b0;
    end else begin
      XMIT_REQ <= cfg_done_r && (!xctl_r || state_nxt == ST_SEND);
    end
  end

  // Two-entry buffer: OUT_DATA is the head, tail_r holds the second word.
  // A full register pair keeps the ready flop exact without a combinational path.
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      cnt_r <= 2'h0;
      OUT_DATA <= '0;
      tail_r <= '0;
      IN_READY <= 1'b0;
      OUT_VALID <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      IN_READY <= cfg_done_r && cnt_nxt != 2'h2;
      OUT_VALID <= cnt_nxt != 2'h0 && state_nxt == ST_SEND;
      if (pop) begin
        OUT_DATA <= cnt_r == 2'h2 ? tail_r : IN_DATA;
        if (push && cnt_r == 2'h2) begin
          tail_r <= IN_DATA;
        end
      end else if (push) begin
        if (cnt_r == 2'h0) begin
          OUT_DATA <= IN_DATA;
        end else begin
          tail_r <= IN_DATA;
        end
      end
    end
  end

  // Checks on the applied settings, supervision, reply timing and transmit request.
  a_baud_default: assert property (@(posedge CLK) disable iff (!RSTN)
    cfg_done_r && baud_r == 3'h3 |-> BAUD_DIV == 17'(`DSPC_DIV_9600)) else $error("bit rate divisor wrong");
  a_parity_map: assert property (@(posedge CLK) disable iff (!RSTN)
    cfg_done_r |-> PARITY_ODD == (par_r == 2'h2) && PARITY_EN == (par_r == 2'h1 || par_r == 2'h2))
    else $error("parity outputs wrong");
  a_stop_passed: assert property (@(posedge CLK) disable iff (!RSTN)
    COMM_FAULT |-> STOP_METHOD == stop_r) else $error("stop method not passed");
  a_no_fault_off: assert property (@(posedge CLK) disable iff (!RSTN)
    cfg_done_r && !det_en_r |=> !COMM_FAULT) else $error("fault with detection off");
  a_fault_late: assert property (@(posedge CLK) disable iff (!RSTN)
    $rose(COMM_FAULT) |-> loss_cnt_r > loss_r && det_en_r) else $error("fault before loss time");
  a_loss_range: assert property (@(posedge CLK) disable iff (!RSTN)
    cfg_done_r |-> loss_r <= `DSPC_LOSS_MAX) else $error("loss time out of range");
  a_reply_wait: assert property (@(posedge CLK) disable iff (!RSTN)
    state_r == ST_SEND && $past(state_r) == ST_WAIT |-> $past(ms_cnt_r) == dly_r - 7'h1 && $past(ms_tick))
    else $error("reply released early");
  a_xreq_send: assert property (@(posedge CLK) disable iff (!RSTN)
    cfg_done_r && xctl_r |-> XMIT_REQ == (state_r == ST_SEND)) else $error("transmit request off send");
  a_xreq_on: assert property (@(posedge CLK) disable iff (!RSTN)
    cfg_done_r && !xctl_r |=> XMIT_REQ [*2]) else $error("transmit request dropped");
  a_proto_legal: assert property (@(posedge CLK) disable iff (!RSTN)
    PROTOCOL != 2'h3) else $error("illegal protocol");
  a_cfg_frozen: assert property (@(posedge CLK) disable iff (!RSTN)
    cfg_done_r |=> $stable(BAUD_DIV) && $stable(PROTOCOL) && $stable(dly_r)) else $error("settings changed");
  a_msg_restart: assert property (@(posedge CLK) disable iff (!RSTN)
    cfg_done_r && MSG_VALID |=> !COMM_FAULT && loss_cnt_r == 7'h0) else $error("message did not restart");
  c_fault: cover property (@(posedge CLK) disable iff (!RSTN) $rose(COMM_FAULT));
  c_send: cover property (@(posedge CLK) disable iff (!RSTN) pop ##1 pop);
  c_full: cover property (@(posedge CLK) disable iff (!RSTN) cnt_r == 2'h2 && !OUT_READY);
endmodule : dspc_top

// File: dv/dspc_ser_model.sv
/*
  Serialiser model standing at the far side of the reply stream.
  Assumes it shares the block's clock and reset and that the bench may stall it.
*/
`timescale 1ns/1ps
module dspc_ser_model (
  // Clock and reset.
  input wire logic clk,
  input wire logic rstn,
  // Word stream from the block.
  input wire logic out_valid,
  output logic out_ready,
  // Stall request from the bench, and shifting status back to the block.
  input wire logic stall,
  output logic tx_busy
);
  // Cycles left of shifting the current word.
  logic [1:0] busy_r;
  // A word is only taken while idle, so a slow line really pushes back on the buffer.
  assign out_ready = !stall && (busy_r == 2'h0);
  assign tx_busy = (busy_r != 2'h0);
  // Each taken word keeps the line busy for three cycles.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      busy_r <= 2'h0;
    end else if (out_valid && out_ready) begin
      busy_r <= 2'h3;
    end else if (busy_r != 2'h0) begin
      busy_r <= busy_r - 2'h1;
    end
  end
endmodule : dspc_ser_model

// File: dv/dspc_top_tb.sv
/*
  Self-checking bench of the serial port control block with a table of strap settings.
  Assumes shortened ms and tenth-second counts; straps change around a reset, and once after capture in the reply test.
*/
`timescale 1ns/1ps
module dspc_top_tb;
  import dspc_pkg::*;
  // One strap setting and the configuration it should give.
  typedef struct packed {
    logic [2:0] b; logic [1:0] p; logic [1:0] s; logic [1:0] pr;
    logic [16:0] div; logic pen; logic podd; logic [1:0] epr;
  } dspc_row_t;
  dspc_row_t rows [6] = '{'{3'h0, 2'h0, 2'h0, 2'h0, 17'h14585, 1'b0, 1'b0, 2'h0},
    '{3'h1, 2'h1, 2'h1, 2'h1, 17'h0a2c2, 1'b1, 1'b0, 2'h1}, '{3'h2, 2'h2, 2'h2, 2'h2, 17'h05161, 1'b1, 1'b1, 2'h2},
    '{3'h3, 2'h3, 2'h3, 2'h0, 17'h028b0, 1'b0, 1'b0, 2'h0}, '{3'h4, 2'h0, 2'h3, 2'h3, 17'h01458, 1'b0, 1'b0, 2'h0},
    '{3'h7, 2'h1, 2'h0, 2'h1, 17'h028b0, 1'b1, 1'b0, 2'h1}};
  // Bench-driven inputs, all given a value at time zero.
  logic clk = 1'b0, rstn = 1'b0, det_en = 1'b1, trc = 1'b1, msg = 1'b0, in_valid = 1'b0, stall = 1'b1;
  logic [2:0] baud = 3'h3;
  logic [1:0] par = 2'h0;
  // The reply delay strap sits below its minimum, so the reply test sees the 5 ms clamp.
  logic [6:0] loss_t = 7'h02, dly_t = 7'h02;
  logic [7:0] in_data = 8'h00;
  dspc_stop_t stop = DSPC_ALARM;
  dspc_proto_t proto = DSPC_MODBUS;
  // Design and serialiser model outputs.
  logic in_ready, out_valid, out_ready, tx_busy, cfg_valid, par_en, par_odd, fault, xreq;
  logic [7:0] out_data;
  logic [16:0] baud_div;
  dspc_proto_t proto_o;
  dspc_stop_t stop_o;
  // Bookkeeping.
  int failures = 0, check_count = 0, cyc = 0;
  logic [7:0] rx [$];
  always #5 clk = ~clk;
  dspc_top #(.CYC_PER_MS(10), .CYC_PER_DSEC(50), .DW(8)) u_dut (.CLK(clk), .RSTN(rstn), .BAUD_SEL(baud),
    .PARITY_SEL(par), .STOP_SEL(stop), .LOSS_DET_EN(det_en), .COMM_LOSS_TIME(loss_t), .REPLY_DELAY_TIME(dly_t),
    .TRANSMIT_REQUEST_CONTROL(trc), .PROTOCOL_SEL(proto), .MSG_VALID(msg), .TX_BUSY(tx_busy), .IN_DATA(in_data),
    .IN_VALID(in_valid), .IN_READY(in_ready), .OUT_DATA(out_data), .OUT_VALID(out_valid), .OUT_READY(out_ready),
    .CFG_VALID(cfg_valid), .BAUD_DIV(baud_div), .PARITY_EN(par_en), .PARITY_ODD(par_odd), .PROTOCOL(proto_o),
    .COMM_FAULT(fault), .STOP_METHOD(stop_o), .XMIT_REQ(xreq));
  dspc_ser_model u_ser (.clk(clk), .rstn(rstn), .out_valid(out_valid), .out_ready(out_ready), .stall(stall),
    .tx_busy(tx_busy));
  // Words are logged at the falling edge, where the handshake is settled.
  always @(negedge clk) begin
    if (out_valid === 1'b1 && out_ready === 1'b1) rx.push_back(out_data);
  end
  // A hang is cut short well past the several hundred cycles the tests need.
  always @(posedge clk) begin
    cyc++;
    if (cyc > 6000) begin
      failures++;
      print_verdict();
    end
  end
  // Compares four-state values so an unknown never passes.
  task automatic chk(input logic [31:0] got_v, input logic [31:0] exp_v, input string what);
    check_count++;
    if (got_v !== exp_v) begin
      failures++;
      $display("[FAIL] %0t %s: got %h, expected %h", $time, what, got_v, exp_v);
    end
  endtask : chk
  // Applies straps under a five-cycle reset and waits for the capture.
  task automatic boot(input logic [2:0] b, input logic [1:0] p, input logic [1:0] s, input logic [1:0] pr,
                      input logic en, input logic tr);
    @(posedge clk);
    baud <= b;
    par <= p;
    stop <= dspc_stop_t'(s);
    proto <= dspc_proto_t'(pr);
    det_en <= en;
    trc <= tr;
    rstn <= 1'b0;
    repeat (4) @(posedge clk);
    @(negedge clk);
    chk(baud_div, 32'h28b0, "reset divisor");
    chk({cfg_valid, fault, xreq, out_valid, in_ready}, 5'h00, "reset outputs");
    // Release on a rising edge, so the first working edge is the next one.
    @(posedge clk);
    rstn <= 1'b1;
    for (int i = 0; i < 10 && cfg_valid !== 1'b1; i++) @(negedge clk);
    chk(cfg_valid, 1'b1, "capture done");
  endtask : boot
  // Offers one word and holds it until the buffer takes it.
  task automatic push(input logic [7:0] d);
    // Raise just after an edge and hold until an edge samples the ready flag high.
    @(posedge clk);
    in_data <= d;
    in_valid <= 1'b1;
    for (int i = 0; i < 300; i++) begin
      @(posedge clk);
      if (in_ready === 1'b1) break;
    end
    in_valid <= 1'b0;
  endtask : push
  // One-cycle message pulse; returns at the edge that samples it.
  task automatic pulse_msg();
    @(posedge clk);
    msg <= 1'b1;
    @(posedge clk);
    msg <= 1'b0;
  endtask : pulse_msg
  // Waits n edges after the message edge, then looks at the fault flag.
  task automatic fault_at(input int n, input logic e);
    repeat (n) @(posedge clk);
    @(negedge clk);
    chk(fault, e, "loss fault");
  endtask : fault_at
  // Prints the counts and the verdict, then ends the run.
  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : print_verdict
  initial begin
    // Table rows: every rate, parity, stop and protocol code, with the fall-back codes.
    for (int i = 0; i < 6; i++) begin
      boot(rows[i].b, rows[i].p, rows[i].s, rows[i].pr, 1'b1, 1'b1);
      chk(baud_div, rows[i].div, "divisor");
      chk({par_en, par_odd}, {rows[i].pen, rows[i].podd}, "parity");
      chk(stop_o, rows[i].s, "stop code");
      chk(proto_o, rows[i].epr, "protocol");
      chk(xreq, 1'b0, "request idle");
    end
    $display("test table done");
    // Reply path: fill the buffer while the line stalls, then send after the delay.
    boot(3'h3, 2'h0, 2'h0, 2'h0, 1'b1, 1'b1);
    push(8'ha1);
    push(8'hb2);
    // A third word waits on the full buffer; straps changed now must not apply.
    @(posedge clk);
    in_data <= 8'hc3;
    in_valid <= 1'b1;
    baud <= 3'h0;
    trc <= 1'b0;
    repeat (2) @(negedge clk);
    chk(in_ready, 1'b0, "buffer full");
    pulse_msg();
    // The reply is released exactly 5 ms, 50 shortened cycles, after the message edge.
    repeat (49) @(posedge clk);
    @(negedge clk);
    chk(out_valid, 1'b0, "reply early");
    @(negedge clk);
    chk({out_valid, xreq, out_data}, {2'h3, 8'ha1}, "reply start");
    @(posedge clk);
    stall <= 1'b0;
    push(8'hc3);
    for (int i = 0; i < 100 && (rx.size() < 3 || xreq !== 1'b0); i++) @(negedge clk);
    chk(rx.size() == 3 ? {rx[0], rx[1], rx[2]} : 24'h0, 24'ha1b2c3, "word order");
    chk(xreq, 1'b0, "request released");
    chk(baud_div, 32'h28b0, "late strap");
    $display("test reply done");
    // Always-on request line.
    boot(3'h3, 2'h0, 2'h0, 2'h0, 1'b1, 1'b0);
    // The request flop follows the capture by one edge.
    @(negedge clk);
    chk(xreq, 1'b1, "request on");
    $display("test request done");
    // Loss timing with a restart by a second message, then clearing.
    boot(3'h3, 2'h0, 2'h2, 2'h0, 1'b1, 1'b1);
    pulse_msg();
    fault_at(100, 1'b0);
    pulse_msg();
    fault_at(149, 1'b0);
    fault_at(1, 1'b1);
    chk(stop_o, 2'h2, "fault stop");
    pulse_msg();
    fault_at(0, 1'b0);
    $display("test loss done");
    // Detection off never faults, even at the shortest time.
    @(posedge clk);
    loss_t <= 7'h00;
    boot(3'h3, 2'h0, 2'h0, 2'h0, 1'b0, 1'b1);
    fault_at(200, 1'b0);
    $display("test detection off done");
    print_verdict();
  end
endmodule : dspc_top_tb
